// ---- shared/drc_pkg.sv ----
// Constants shared by the disk read channel path
package drc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MATCH_WAIT_US = 70;
  localparam int MATCH_WAIT_CYC = MATCH_WAIT_US * CLK_MHZ;
  localparam int STROBE_DELAY_NS = 200;
  localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_SECCNT = 8'h0c;
  localparam logic [7:0] OFS_STORE = 8'h10;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_BIT = 2;
  localparam logic [1:0] MODE_READ = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h3;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CSTOP = 2;
  localparam int ST_ASTOP = 3;
  localparam int ST_FLAG = 4;
  localparam int ST_REQ = 5;
  localparam int ST_SEL = 6;
  localparam int ST_XFER = 7;
  localparam int ST_GATE = 8;
  localparam int ST_DIR = 9;
  localparam int ST_FIRST = 10;
  localparam int ST_SECOND = 11;

  // ----------------------------------------------------------------
  // Word geometry and pin synchroniser indices
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam int HALF_BITS = 16;
  localparam logic [5:0] WORD_COUNT_FULL = 6'h20;
  localparam int PIN_N = 8;
  localparam int PIN_SEC_EQ = 0;
  localparam int PIN_SEC_END = 1;
  localparam int PIN_RCLK = 2;
  localparam int PIN_RDATA = 3;
  localparam int PIN_REQEN = 4;
  localparam int PIN_ACK = 5;
  localparam int PIN_PRIO = 6;
  localparam int PIN_DIN = 7;

endpackage : drc_pkg

// ---- verilog/drc_read_path.sv ----
// Disk read channel path: disk bit capture, word storage, data channel hand-off
`timescale 1ns/1ps
module drc_read_path #(
  parameter int MATCH_WAIT = drc_pkg::MATCH_WAIT_CYC,
  parameter int SC_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Disk drive side
  input wire logic sector_equal_i,
  input wire logic sector_end_i,
  input wire logic disk_read_clock_i,
  input wire logic disk_read_data_i,
  output logic read_gate_n_o,
  // Processor data channel side
  input wire logic request_enable_n_i,
  input wire logic channel_acknowledge_n_i,
  input wire logic priority_chain_in_i,
  input wire logic channel_data_in_i,
  output logic channel_request_line_n_o,
  output logic channel_mode_line_n_o,
  output logic [15:0] bus_data_o,
  output logic bus_data_oe_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [drc_pkg::PIN_N-1:0] pins_w;
  logic [drc_pkg::PIN_N-1:0] s1_q;
  logic [drc_pkg::PIN_N-1:0] s2_q;
  logic [drc_pkg::PIN_N-1:0] s3_q;
  logic [drc_pkg::PIN_N-1:0] lvl_q;
  logic [drc_pkg::PIN_N-1:0] rise_w;
  logic [drc_pkg::PIN_N-1:0] fall_w;

  // Active-low bus pins are inverted so every event is a rising edge
  assign pins_w = {channel_data_in_i, priority_chain_in_i, ~channel_acknowledge_n_i, ~request_enable_n_i,
                   disk_read_data_i, disk_read_clock_i, sector_end_i, sector_equal_i};

  // A change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < drc_pkg::PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pins_w[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            lvl_q[gi] <= s3_q[gi];
          end
        end
      end
      assign rise_w[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !lvl_q[gi];
      assign fall_w[gi] = (s2_q[gi] == s3_q[gi]) && !s3_q[gi] && lvl_q[gi];
    end
  endgenerate

  // Three stages plus agreement is the settled level of a pin
  function automatic logic pin_level(input logic [drc_pkg::PIN_N-1:0] lv, input int idx);
    pin_level = lv[idx];
  endfunction : pin_level

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic busy_q, busy_d;
  logic done_q;
  logic cstop_q, astop_q, adone_q;
  logic dir_q;
  logic [15:0] addr_q;
  logic [SC_W-1:0] seccnt_q;
  logic sc_msb_prev_q;
  logic [12:0] match_cnt_q;
  logic match_wait_q;
  logic gate_q;
  logic xfer_q;
  logic [4:0] strobe_cnt_q;
  logic [31:0] shift_q;
  logic [5:0] bit_cnt_q;
  logic word_done_q;
  logic [31:0] store_q;
  logic flag_q;
  logic req_q;
  logic sel_q;
  logic first_q;
  logic second_q;
  logic addr_phase_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [15:0] bus_q;
  logic oe_q;
  logic mode_n_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wb_req_w, wb_wr_w;
  logic hit_ctrl_w, hit_addr_w, hit_sc_w;
  logic control_phase_one;
  logic read_cmd_n;
  assign wb_req_w = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr_w = wb_req_w && wb_we_i && wb_sel_i[0];
  assign hit_ctrl_w = wb_wr_w && (wb_adr_i == drc_pkg::OFS_CTRL);
  assign hit_addr_w = wb_wr_w && (wb_adr_i == drc_pkg::OFS_ADDR);
  assign hit_sc_w = wb_wr_w && (wb_adr_i == drc_pkg::OFS_SECCNT);
  // Start with mode 00 decodes as read; other modes are not handled here
  assign control_phase_one = hit_ctrl_w && wb_dat_i[drc_pkg::CTRL_START_BIT] && !busy_q;
  assign read_cmd_n = !(busy_q && (mode_q == drc_pkg::MODE_READ));

  // ----------------------------------------------------------------
  // Disk side decode
  // ----------------------------------------------------------------
  logic bit_clock_pulse, strobe_pulse, bit_step, shift_pulse, word_complete;
  logic sync_seen_w, sector_over_w, match_done_w;
  assign bit_clock_pulse = rise_w[drc_pkg::PIN_RCLK];
  assign strobe_pulse = (strobe_cnt_q == 5'h01);
  assign bit_step = bit_clock_pulse && xfer_q;
  assign shift_pulse = strobe_pulse && xfer_q;
  assign word_complete = word_done_q;
  assign sync_seen_w = gate_q && !xfer_q && bit_clock_pulse &&
                       s2_q[drc_pkg::PIN_RDATA] && s3_q[drc_pkg::PIN_RDATA];
  assign sector_over_w = busy_q && rise_w[drc_pkg::PIN_SEC_END];
  assign match_done_w = match_wait_q && (match_cnt_q == 13'h0001);

  // ----------------------------------------------------------------
  // Data channel decode
  // ----------------------------------------------------------------
  logic reqen_ev, ack_ev, din_rise, din_level, arm_sel_w;
  logic flag_clear_pulse, address_increment, store_low_load, store_high_load;
  logic [31:0] store_src_w;
  logic [15:0] half_w;
  assign reqen_ev = rise_w[drc_pkg::PIN_REQEN];
  assign ack_ev = rise_w[drc_pkg::PIN_ACK];
  assign din_rise = rise_w[drc_pkg::PIN_DIN] && sel_q;
  assign din_level = pin_level(lvl_q, drc_pkg::PIN_DIN) && sel_q;
  assign arm_sel_w = req_q && pin_level(lvl_q, drc_pkg::PIN_PRIO);
  assign flag_clear_pulse = ack_ev && arm_sel_w;
  assign address_increment = din_rise;
  // Both halves strobe together so a word is never split across reads
  assign store_low_load = word_complete && !read_cmd_n;
  assign store_high_load = word_complete && !read_cmd_n;
  assign store_src_w = read_cmd_n ? store_q : shift_q;
  assign half_w = second_q ? store_q[31:16] : store_q[15:0];

  // Busy falls in the very edge that done rises
  assign busy_d = adone_q ? 1'b0 : (control_phase_one ? 1'b1 : busy_q);

  // ----------------------------------------------------------------
  // Command, stop and done sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= drc_pkg::MODE_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dir_q <= 1'b0;
      cstop_q <= 1'b0;
      astop_q <= 1'b0;
      adone_q <= 1'b0;
      sc_msb_prev_q <= 1'b0;
      seccnt_q <= '0;
      addr_q <= 16'h0000;
    end else begin
      busy_q <= busy_d;
      if (hit_ctrl_w && !busy_q) begin
        mode_q <= wb_dat_i[drc_pkg::CTRL_MODE_LSB +: 2];
      end
      if (control_phase_one) begin
        done_q <= 1'b0;
        cstop_q <= 1'b0;
        astop_q <= 1'b0;
        dir_q <= (wb_dat_i[drc_pkg::CTRL_MODE_LSB +: 2] == drc_pkg::MODE_READ);
      end else begin
        // Overflow of the two's-complement count ends the run
        if (busy_q && sc_msb_prev_q && !seccnt_q[SC_W-1]) begin
          cstop_q <= 1'b1;
        end
        if (cstop_q && !read_cmd_n) begin
          astop_q <= 1'b1;
        end
        if (adone_q) begin
          done_q <= 1'b1;
          dir_q <= 1'b0;
        end
      end
      adone_q <= astop_q && busy_q && !adone_q;
      sc_msb_prev_q <= seccnt_q[SC_W-1];
      if (hit_sc_w && !busy_q) begin
        seccnt_q <= wb_dat_i[SC_W-1:0];
      end else if (sector_over_w) begin
        seccnt_q <= seccnt_q + 1'b1;
      end
      if (hit_addr_w && !busy_q) begin
        addr_q <= wb_dat_i[15:0];
      end else if (address_increment) begin
        addr_q <= addr_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sector search and read gate
  // ----------------------------------------------------------------
  // Long wait is a parameter so simulation can shorten it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_wait_q <= 1'b0;
      match_cnt_q <= 13'h0000;
      gate_q <= 1'b0;
      xfer_q <= 1'b0;
    end else begin
      if (!busy_q || cstop_q || sector_over_w) begin
        match_wait_q <= 1'b0;
        gate_q <= 1'b0;
        xfer_q <= 1'b0;
      end else begin
        if (rise_w[drc_pkg::PIN_SEC_EQ] && !gate_q && !match_wait_q && !read_cmd_n) begin
          match_wait_q <= 1'b1;
          match_cnt_q <= 13'(MATCH_WAIT);
        end else if (match_wait_q) begin
          match_cnt_q <= match_cnt_q - 13'h0001;
          if (match_done_w) begin
            match_wait_q <= 1'b0;
            gate_q <= 1'b1;
          end
        end
        if (sync_seen_w) begin
          xfer_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit capture and word assembly
  // ----------------------------------------------------------------
  // Data is sampled at the delayed strobe, well inside the bit cell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_cnt_q <= 5'h00;
      shift_q <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
      word_done_q <= 1'b0;
      store_q <= 32'h0000_0000;
    end else begin
      if (bit_clock_pulse) begin
        strobe_cnt_q <= 5'(drc_pkg::STROBE_DELAY_CYC);
      end else if (strobe_cnt_q != 5'h00) begin
        strobe_cnt_q <= strobe_cnt_q - 5'h01;
      end
      if (shift_pulse) begin
        shift_q <= {shift_q[30:0], pin_level(lvl_q, drc_pkg::PIN_RDATA)};
      end
      word_done_q <= shift_pulse && (bit_cnt_q == drc_pkg::WORD_COUNT_FULL);
      if (control_phase_one || word_complete) begin
        bit_cnt_q <= 6'h00;
      end else if (bit_step) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (store_low_load) begin
        store_q[15:0] <= store_src_w[15:0];
      end
      if (store_high_load) begin
        store_q[31:16] <= store_src_w[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer flag and channel handshake
  // ----------------------------------------------------------------
  // Flag set beats a clear landing in the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
      req_q <= 1'b0;
      sel_q <= 1'b0;
      first_q <= 1'b0;
      second_q <= 1'b0;
      addr_phase_q <= 1'b0;
    end else begin
      if (control_phase_one) begin
        flag_q <= 1'b0;
        first_q <= 1'b0;
        second_q <= 1'b0;
      end else begin
        if (word_complete && busy_q) begin
          flag_q <= 1'b1;
        end else if (flag_clear_pulse && first_q) begin
          flag_q <= 1'b0;
        end
        if (flag_clear_pulse) begin
          first_q <= !first_q;
          second_q <= first_q;
        end
      end
      if (reqen_ev) begin
        req_q <= flag_q;
      end
      if (ack_ev) begin
        sel_q <= arm_sel_w;
      end
      if (flag_clear_pulse) begin
        addr_phase_q <= 1'b1;
      end else if (din_rise) begin
        addr_phase_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= 16'h0000;
      oe_q <= 1'b0;
      mode_n_q <= 1'b1;
    end else begin
      mode_n_q <= !(sel_q && dir_q);
      // Address rides the bus until data-in, then the selected half
      if (addr_phase_q && !din_level) begin
        bus_q <= addr_q;
        oe_q <= 1'b1;
      end else if (din_level) begin
        bus_q <= half_w;
        oe_q <= 1'b1;
      end else begin
        bus_q <= 16'h0000;
        oe_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read data and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] status_w, rmux_w;
  assign status_w = {20'h00000, second_q, first_q, dir_q, gate_q, xfer_q, sel_q, req_q, flag_q,
                     astop_q, cstop_q, done_q, busy_q};
  // Unmapped offsets read zero and ignore writes
  assign rmux_w = (wb_adr_i == drc_pkg::OFS_CTRL) ? {29'h0000_0000, 1'b0, mode_q} :
                  (wb_adr_i == drc_pkg::OFS_STATUS) ? status_w :
                  (wb_adr_i == drc_pkg::OFS_ADDR) ? {16'h0000, addr_q} :
                  (wb_adr_i == drc_pkg::OFS_SECCNT) ? {{(32 - SC_W){1'b0}}, seccnt_q} :
                  (wb_adr_i == drc_pkg::OFS_STORE) ? store_q : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req_w;
      rdat_q <= wb_req_w ? rmux_w : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign read_gate_n_o = !gate_q;
  assign channel_request_line_n_o = !req_q;
  assign channel_mode_line_n_o = mode_n_q;
  assign bus_data_o = bus_q;
  assign bus_data_oe_o = oe_q;

endmodule : drc_read_path

// ---- tb/drc_read_path_monitor.sv ----
// Port checker for the disk read channel path
`timescale 1ns/1ps
module drc_read_path_monitor #(
  parameter int MATCH_WAIT = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Drive and channel pins
  input wire logic sector_equal_i,
  input wire logic read_gate_n_o,
  input wire logic request_enable_n_i,
  input wire logic channel_acknowledge_n_i,
  input wire logic channel_data_in_i,
  input wire logic channel_request_line_n_o,
  input wire logic channel_mode_line_n_o,
  input wire logic bus_data_oe_o
);
  logic [15:0] eq_age_q;
  logic [7:0] ren_age_q;
  logic [7:0] ack_age_q;

  // Cycles since each pin event; saturating so a stale event never looks recent
  always_ff @(posedge clk_i) begin
    if (rst_i || $rose(sector_equal_i)) begin
      eq_age_q <= 16'h0000;
    end else if (eq_age_q != 16'hffff) begin
      eq_age_q <= eq_age_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ren_age_q <= 8'hff;
      ack_age_q <= 8'hff;
    end else begin
      ren_age_q <= !request_enable_n_i ? 8'h00 : ren_age_q + {7'h00, ren_age_q != 8'hff};
      ack_age_q <= !channel_acknowledge_n_i ? 8'h00 : ack_age_q + {7'h00, ack_age_q != 8'hff};
    end
  end

  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answers: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_gate_waits: assert property ($fell(read_gate_n_o) |-> eq_age_q >= MATCH_WAIT)
    else $error("read gate opened before the match wait ran out");
  a_req_sets: assert property ($fell(channel_request_line_n_o) |-> ren_age_q <= 10)
    else $error("request raised without a request enable");
  a_req_drops: assert property ($rose(channel_request_line_n_o) |-> ren_age_q <= 10)
    else $error("request released without a request enable");
  a_mode_select: assert property ($fell(channel_mode_line_n_o) |-> ack_age_q <= 10)
    else $error("mode line low without an acknowledge");
  a_oe_cause: assert property ($rose(bus_data_oe_o) |-> (ack_age_q <= 12 || channel_data_in_i))
    else $error("bus drivers enabled without ack or data in");
  a_oe_drops: assert property ($fell(channel_data_in_i) |-> ##[1:8] !bus_data_oe_o)
    else $error("bus drivers held after data in ended");
  c_gate: cover property ($fell(read_gate_n_o));
  c_req_end: cover property ($rose(channel_request_line_n_o));
  c_mode: cover property ($fell(channel_mode_line_n_o));
endmodule : drc_read_path_monitor

bind drc_read_path drc_read_path_monitor #(.MATCH_WAIT(MATCH_WAIT)) u_drc_read_path_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sector_equal_i(sector_equal_i), .read_gate_n_o(read_gate_n_o),
  .request_enable_n_i(request_enable_n_i), .channel_acknowledge_n_i(channel_acknowledge_n_i),
  .channel_data_in_i(channel_data_in_i), .channel_request_line_n_o(channel_request_line_n_o),
  .channel_mode_line_n_o(channel_mode_line_n_o), .bus_data_oe_o(bus_data_oe_o));

// ---- tb/drc_host_model.sv ----
// Processor data channel model answering the read path
`timescale 1ns/1ps
module drc_host_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  // From the device
  input wire logic channel_request_line_n_i,
  input wire logic channel_mode_line_n_i,
  input wire logic [15:0] bus_data_i,
  input wire logic bus_data_oe_i,
  // To the device
  output logic request_enable_n_o,
  output logic channel_acknowledge_n_o,
  output logic priority_chain_in_o,
  output logic channel_data_in_o
);
  logic [17:0] got_q[$];
  logic served;
  logic skipped;
  logic [17:0] idle_seen;
  int gap;
  // Open collector bus with pull-up: undriven lines read as ones
  wire logic [15:0] bus_wire = bus_data_oe_i ? bus_data_i : 16'hffff;

  task automatic pulse_ack();
    channel_acknowledge_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    channel_acknowledge_n_o <= 1'b1;
  endtask : pulse_ack

  // Polls with request enable; data-in wait alternates to act prompt and slow
  initial begin
    request_enable_n_o = 1'b1;
    channel_acknowledge_n_o = 1'b1;
    priority_chain_in_o = 1'b1;
    channel_data_in_o = 1'b0;
    served = 1'b0;
    skipped = 1'b0;
    idle_seen = 18'h00000;
    gap = 8;
    forever begin
      repeat (12) @(posedge clk_i);
      if (run_i && !rst_i) begin
        request_enable_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        request_enable_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        if (channel_request_line_n_i === 1'b0 && !skipped) begin
          // First request meets an acknowledge without priority, which must pass it by
          priority_chain_in_o <= 1'b0;
          repeat (6) @(posedge clk_i);
          pulse_ack();
          repeat (8) @(posedge clk_i);
          idle_seen = {bus_data_oe_i, channel_mode_line_n_i, bus_wire};
          priority_chain_in_o <= 1'b1;
          skipped = 1'b1;
        end else if (channel_request_line_n_i === 1'b0) begin
          pulse_ack();
          repeat (gap) @(posedge clk_i);
          got_q.push_back({bus_data_oe_i, channel_mode_line_n_i, bus_wire});
          channel_data_in_o <= 1'b1;
          repeat (8) @(posedge clk_i);
          got_q.push_back({bus_data_oe_i, channel_mode_line_n_i, bus_wire});
          channel_data_in_o <= 1'b0;
          served = 1'b1;
          gap = (gap == 8) ? 24 : 8;
        end else if (served) begin
          pulse_ack();
          served = 1'b0;
        end
      end
    end
  end
endmodule : drc_host_model

// ---- tb/drc_read_path_bench.sv ----
// Self-checking bench for the disk read channel path
`timescale 1ns/1ps
module drc_read_path_bench;
  // ----------
  // Signals
  // ----------
  localparam int MW = 20;
  localparam logic [31:0] WORD = 32'hc3a5_1e69;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h1;
  logic [31:0] wb_dat = 32'h0, wb_q, st;
  logic sec_eq = 1'b0, sec_end = 1'b0, dclk = 1'b0, ddat = 1'b0, run = 1'b0;
  logic ren_n, ack_n, prio, din, req_n, mode_n, oe, gate_n;
  logic [15:0] bus;
  int err_total = 0;
  int total_checks = 0;
  int n;

  always #5 clk_i = ~clk_i;

  drc_read_path #(.MATCH_WAIT(MW), .SC_W(8)) u_drc_read_path (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .sector_equal_i(sec_eq), .sector_end_i(sec_end), .disk_read_clock_i(dclk), .disk_read_data_i(ddat),
    .read_gate_n_o(gate_n), .request_enable_n_i(ren_n), .channel_acknowledge_n_i(ack_n),
    .priority_chain_in_i(prio), .channel_data_in_i(din), .channel_request_line_n_o(req_n),
    .channel_mode_line_n_o(mode_n), .bus_data_o(bus), .bus_data_oe_o(oe));

  drc_host_model u_drc_host_model (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .channel_request_line_n_i(req_n),
    .channel_mode_line_n_i(mode_n), .bus_data_i(bus), .bus_data_oe_i(oe), .request_enable_n_o(ren_n),
    .channel_acknowledge_n_o(ack_n), .priority_chain_in_o(prio), .channel_data_in_o(din));

  // ----------
  // Shared tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = wb_q;
    chk("bus_ack", 32'(k < 50), 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Data held over the whole bit so the delayed strobe sees it
  task automatic send_bit(input logic b);
    ddat <= b;
    dclk <= 1'b1;
    repeat (4) @(posedge clk_i);
    dclk <= 1'b0;
    repeat (26) @(posedge clk_i);
  endtask : send_bit

  task automatic pulse_end();
    sec_end <= 1'b1;
    repeat (4) @(posedge clk_i);
    sec_end <= 1'b0;
    repeat (30) @(posedge clk_i);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
  endtask : pulse_end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    chk("idle_pins", 32'({gate_n, req_n, mode_n, oe}), 32'he);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("status_reset", st, 32'h0);
    wb(1'b0, 8'h1c, 32'h0, st);
    chk("unmapped", st, 32'h0);
  endtask : t_reset

  task automatic t_start();
    wb(1'b1, drc_pkg::OFS_ADDR, 32'h0000_0100, st);
    wb(1'b1, drc_pkg::OFS_SECCNT, 32'h0000_00fe, st);
    wb(1'b1, drc_pkg::OFS_CTRL, 32'h0000_0004, st);
    wb(1'b1, drc_pkg::OFS_ADDR, 32'h0000_5555, st);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("start_status", st, 32'h0000_0201);
  endtask : t_start

  task automatic t_gate();
    n = 0;
    sec_eq <= 1'b1;
    repeat (4) @(posedge clk_i);
    sec_eq <= 1'b0;
    while (gate_n !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("gate_wait", 32'(n + 4 >= MW && n + 4 <= MW + 12), 32'h1);
  endtask : t_gate

  task automatic t_word();
    for (int i = 0; i < 3; i++) begin
      send_bit(1'b0);
    end
    send_bit(1'b1);
    for (int i = 31; i > 0; i--) begin
      send_bit(WORD[i]);
    end
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("flag_31_xfer", 32'({st[drc_pkg::ST_FLAG], st[drc_pkg::ST_XFER]}), 32'h1);
    send_bit(WORD[0]);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("flag_32", 32'(st[drc_pkg::ST_FLAG]), 32'h1);
    chk("no_req_yet", 32'(req_n), 32'h1);
    wb(1'b0, drc_pkg::OFS_STORE, 32'h0, st);
    chk("store", st, WORD);
  endtask : t_word

  task automatic t_channel();
    run <= 1'b1;
    n = 0;
    while (u_drc_host_model.got_q.size() < 4 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk("no_prio", 32'(u_drc_host_model.idle_seen), {14'h0, 2'b01, 16'hffff});
    chk("addr_a", 32'(u_drc_host_model.got_q[0]), {14'h0, 2'b10, 16'h0100});
    chk("data_lo", 32'(u_drc_host_model.got_q[1]), {14'h0, 2'b10, WORD[15:0]});
    chk("addr_b", 32'(u_drc_host_model.got_q[2]), {14'h0, 2'b10, 16'h0101});
    chk("data_hi", 32'(u_drc_host_model.got_q[3]), {14'h0, 2'b10, WORD[31:16]});
    repeat (150) @(posedge clk_i);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("after_pair", st & 32'h0000_0c70, 32'h0000_0800);
    wb(1'b0, drc_pkg::OFS_ADDR, 32'h0, st);
    chk("addr_next", st, 32'h0000_0102);
  endtask : t_channel

  task automatic t_stop();
    pulse_end();
    chk("no_stop_yet", 32'(st[drc_pkg::ST_BUSY]), 32'h1);
    pulse_end();
    chk("done", st & 32'h0000_0003, 32'h0000_0002);
    chk("gate_closed", 32'(gate_n), 32'h1);
    wb(1'b1, drc_pkg::OFS_CTRL, 32'h0000_0004, st);
    wb(1'b0, drc_pkg::OFS_STATUS, 32'h0, st);
    chk("restart", st & 32'h0000_0c13, 32'h0000_0001);
  endtask : t_stop

  // ----------
  // Main sequence and watchdog
  // ----------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_start();
    t_gate();
    t_word();
    t_channel();
    t_stop();
    tally_and_finish();
  end

  // Whole run needs roughly 1500 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule : drc_read_path_bench
